// *** logic/alu_pkg.sv ***
// alu_pkg: shared constants and types of the arithmetic and logic unit
// Notes on behaviour
// - size code picks byte, word or longword width
// - add and subtract at all three sizes
// - byte immediate subtract refused as bad operation
// - carry add and borrow subtract are byte only
// - increment and decrement step by one or two
// - byte increment and decrement step one only
// - address step ops: longword, constant one/two/four
// - decimal fix uses carry and half carry
// - unsigned product gives double width result
// - signed product gives double width result
// - unsigned quotient and remainder of divisor width
// - signed quotient and remainder of divisor width
// - compare updates flags only, no writeback
// - negate writes zero minus destination
// - zero widen fills upper half with zeros
// - sign widen copies sign into upper half
// - and with register or immediate operand
// - or with register or immediate operand
// - exclusive or with register or immediate
// - not inverts every bit at width
package alu_pkg;

  // ====
  // widths
  localparam int DATA_W  = 32;
  localparam int STEP_W  = 3;
  localparam int FLAG_W  = 5;
  localparam int DEN_W   = 16;

  // ====
  // flag positions in the condition flags vector
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_H = 4;

  // ====
  // width masks, sign bits and half carry bits
  localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
  localparam logic [31:0] MASK_WORD = 32'h0000_ffff;
  localparam logic [31:0] MASK_LONG = 32'hffff_ffff;
  localparam int MSB_BYTE  = 7;
  localparam int MSB_WORD  = 15;
  localparam int MSB_LONG  = 31;
  localparam int HALF_BYTE = 4;
  localparam int HALF_WORD = 12;
  localparam int HALF_LONG = 28;

  // ====
  // step constants and decimal fix values
  localparam logic [2:0] STEP_ONE  = 3'h1;
  localparam logic [2:0] STEP_TWO  = 3'h2;
  localparam logic [2:0] STEP_FOUR = 3'h4;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX  = 8'h99;
  localparam logic [7:0] BCD_LO_FIX    = 8'h06;
  localparam logic [7:0] BCD_HI_FIX    = 8'h60;

  // ====
  // operand sizes and operations
  typedef enum logic [1:0] {
    sz_bad  = 2'b00,
    sz_byte = 2'b01,
    sz_word = 2'b10,
    sz_long = 2'b11
  } size_type;

  typedef enum logic [4:0] {
    op_add                  = 5'h00,
    op_sub                  = 5'h01,
    carry_sum_op            = 5'h02,
    borrow_diff_op          = 5'h03,
    op_inc                  = 5'h04,
    op_dec                  = 5'h05,
    addr_step_plus          = 5'h06,
    addr_step_minus         = 5'h07,
    decimal_fix_after_plus  = 5'h08,
    decimal_fix_after_minus = 5'h09,
    unsigned_product_op     = 5'h0a,
    signed_product_op       = 5'h0b,
    unsigned_quotient_op    = 5'h0c,
    signed_quotient_op      = 5'h0d,
    op_cmp                  = 5'h0e,
    op_neg                  = 5'h0f,
    zero_widen_op           = 5'h10,
    sign_widen_op           = 5'h11,
    op_and                  = 5'h12,
    op_or                   = 5'h13,
    op_xor                  = 5'h14,
    op_not                  = 5'h15
  } op_type;

endpackage : alu_pkg

// *** logic/alu_divider.sv ***
// alu_divider: restoring unsigned divider, one quotient bit per clock
`timescale 1ns/10ps
module alu_divider
#(
  parameter int NUM_W = 32,
  parameter int DEN_W = 16
)
(
  // clock and reset
  input  logic             ref_clk,
  input  logic             nrst,
  // request
  input  logic             start,
  input  logic [NUM_W-1:0] dividend,
  input  logic [DEN_W-1:0] divisor,
  // answer
  output logic             done_ff,
  output logic [NUM_W-1:0] quot_ff,
  output logic [DEN_W-1:0] rem_ff
);

  localparam int CNT_W = $clog2(NUM_W + 1);

  logic [DEN_W-1:0] den_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             run_ff;
  logic [DEN_W:0]   trial;

  // ====
  // trial subtraction
  always_comb
  begin
    trial = {rem_ff, quot_ff[NUM_W-1]} - {1'b0, den_ff};
  end

  // ====
  // sequencing
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      run_ff  <= 1'b0;
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= run_ff && (cnt_ff == CNT_W'(1));
      if (start)
      begin
        run_ff <= 1'b1;
        cnt_ff <= CNT_W'(NUM_W);
      end
      else if (run_ff)
      begin
        cnt_ff <= cnt_ff - CNT_W'(1);
        run_ff <= (cnt_ff != CNT_W'(1));
      end
    end
  end

  // ====
  // datapath
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      den_ff  <= '0;
      rem_ff  <= '0;
      quot_ff <= '0;
    end
    else if (start)
    begin
      den_ff  <= divisor;
      rem_ff  <= '0;
      quot_ff <= dividend;
    end
    else if (run_ff)
    begin
      if (!trial[DEN_W])
      begin
        rem_ff  <= trial[DEN_W-1:0];
        quot_ff <= {quot_ff[NUM_W-2:0], 1'b1};
      end
      else
      begin
        rem_ff  <= {rem_ff[DEN_W-2:0], quot_ff[NUM_W-1]};
        quot_ff <= {quot_ff[NUM_W-2:0], 1'b0};
      end
    end
  end

endmodule : alu_divider

// *** logic/cpu_arith_logic_unit.sv ***
// cpu_arith_logic_unit: arithmetic and logic execution datapath
`timescale 1ns/10ps
module cpu_arith_logic_unit
(
  // clock and reset
  input  logic                          ref_clk,
  input  logic                          nrst,
  // request from the decoder
  input  logic                          req_valid,
  input  alu_pkg::op_type               op,
  input  alu_pkg::size_type             size,
  input  logic                          use_imm,
  input  logic [alu_pkg::STEP_W-1:0]    step_val,
  // operands from the register file
  input  logic [alu_pkg::DATA_W-1:0]    dst_val,
  input  logic [alu_pkg::DATA_W-1:0]    src_gpr,
  input  logic [alu_pkg::DATA_W-1:0]    imm_val,
  // flags from the condition flags register
  input  logic [alu_pkg::FLAG_W-1:0]    flags_in,
  // answer
  output logic                          busy_ff,
  output logic                          done_ff,
  output logic                          bad_op_ff,
  output logic                          wr_en_ff,
  output logic [alu_pkg::DATA_W-1:0]    res_ff,
  output logic                          flags_we_ff,
  output logic [alu_pkg::FLAG_W-1:0]    flags_ff
);

  import alu_pkg::*;

  // ====
  // width decoding
  function automatic logic [31:0] width_mask(input size_type s);
    unique case (s)
      sz_byte: width_mask = MASK_BYTE;
      sz_word: width_mask = MASK_WORD;
      sz_long: width_mask = MASK_LONG;
      sz_bad:  width_mask = MASK_LONG;
    endcase
  endfunction : width_mask

  function automatic int msb_of(input size_type s);
    unique case (s)
      sz_byte: msb_of = MSB_BYTE;
      sz_word: msb_of = MSB_WORD;
      sz_long: msb_of = MSB_LONG;
      sz_bad:  msb_of = MSB_LONG;
    endcase
  endfunction : msb_of

  function automatic int half_of(input size_type s);
    unique case (s)
      sz_byte: half_of = HALF_BYTE;
      sz_word: half_of = HALF_WORD;
      sz_long: half_of = HALF_LONG;
      sz_bad:  half_of = HALF_LONG;
    endcase
  endfunction : half_of

  // ====
  // declarations
  logic [31:0]       opnd;
  logic [31:0]       fm;
  logic [31:0]       aa;
  logic [31:0]       ab;
  logic              cc;
  logic              do_sub;
  logic              use_arith;
  logic [31:0]       direct;
  logic              direct_c;
  size_type          wsize;
  size_type          fsize;
  logic              wr;
  logic              upd_nz;
  logic              upd_v;
  logic              upd_c;
  logic              upd_h;
  logic              sticky_z;
  logic              bad;
  logic              div_go;
  logic              dec_lo;
  logic              dec_hi;
  logic [7:0]        dec_adj;
  logic              mul_sgn;
  logic [31:0]       mul_a;
  logic [31:0]       mul_b;
  logic [31:0]       prod;
  logic [32:0]       sum;
  logic [31:0]       rslt;
  logic [31:0]       hx;
  logic              ovf;
  logic [FLAG_W-1:0] nf;
  logic [31:0]       wm;
  logic [31:0]       merged;
  logic              acc;
  logic              div_sgn;
  logic [31:0]       dd_s;
  logic [15:0]       dv_s;
  logic              neg_a;
  logic              neg_b;
  logic [31:0]       dd_abs;
  logic [15:0]       dv_abs;
  logic              div_done;
  logic [31:0]       div_quot;
  logic [15:0]       div_rem;
  logic [31:0]       q_fix;
  logic [15:0]       r_fix;
  logic [31:0]       div_merged;
  logic [FLAG_W-1:0] div_flags;
  logic [31:0]       ctx_dst_ff;
  logic              ctx_byte_ff;
  logic              ctx_nq_ff;
  logic              ctx_nr_ff;
  logic              ctx_zero_ff;
  logic [FLAG_W-1:0] ctx_flags_ff;

  assign acc = req_valid && !busy_ff;

  // ====
  // operation decode and direct results
  always_comb
  begin
    opnd      = use_imm ? imm_val : src_gpr;
    fm        = width_mask(size);
    aa        = dst_val & fm;
    ab        = opnd & fm;
    cc        = 1'b0;
    do_sub    = 1'b0;
    use_arith = 1'b1;
    direct    = 32'h0;
    direct_c  = flags_in[FLAG_C];
    wsize     = size;
    fsize     = size;
    wr        = 1'b1;
    upd_nz    = 1'b1;
    upd_v     = 1'b1;
    upd_c     = 1'b1;
    upd_h     = 1'b0;
    sticky_z  = 1'b0;
    bad       = (size == sz_bad);
    div_go    = 1'b0;
    dec_lo    = 1'b0;
    dec_hi    = 1'b0;
    dec_adj   = 8'h00;
    mul_sgn   = (op == signed_product_op);
    mul_a     = 32'h0;
    mul_b     = 32'h0;
    prod      = 32'h0;
    case (op)
      op_add:
      begin
        upd_h = 1'b1;
      end
      op_sub:
      begin
        do_sub = 1'b1;
        upd_h  = 1'b1;
        bad    = bad || (size == sz_byte && use_imm);
      end
      carry_sum_op, borrow_diff_op:
      begin
        do_sub   = (op == borrow_diff_op);
        cc       = flags_in[FLAG_C];
        upd_h    = 1'b1;
        sticky_z = 1'b1;
        bad      = bad || (size != sz_byte);
      end
      op_inc, op_dec:
      begin
        do_sub = (op == op_dec);
        ab     = 32'(step_val);
        upd_c  = 1'b0;
        bad    = bad || !(step_val == STEP_ONE || step_val == STEP_TWO);
        bad    = bad || (size == sz_byte && step_val != STEP_ONE);
      end
      addr_step_plus, addr_step_minus:
      begin
        do_sub = (op == addr_step_minus);
        ab     = 32'(step_val);
        upd_nz = 1'b0;
        upd_v  = 1'b0;
        upd_c  = 1'b0;
        bad    = bad || (size != sz_long);
        bad    = bad || !(step_val == STEP_ONE || step_val == STEP_TWO
                          || step_val == STEP_FOUR);
      end
      decimal_fix_after_plus:
      begin
        use_arith = 1'b0;
        upd_v     = 1'b0;
        dec_lo    = flags_in[FLAG_H] || (aa[3:0] > BCD_DIGIT_MAX);
        dec_hi    = flags_in[FLAG_C] || (aa[7:0] > BCD_BYTE_MAX);
        dec_adj   = (dec_hi ? BCD_HI_FIX : 8'h00) | (dec_lo ? BCD_LO_FIX : 8'h00);
        direct    = 32'(aa[7:0] + dec_adj);
        direct_c  = dec_hi;
        bad       = bad || (size != sz_byte);
      end
      decimal_fix_after_minus:
      begin
        use_arith = 1'b0;
        upd_v     = 1'b0;
        dec_lo    = flags_in[FLAG_H];
        dec_hi    = flags_in[FLAG_C];
        dec_adj   = (dec_hi ? BCD_HI_FIX : 8'h00) | (dec_lo ? BCD_LO_FIX : 8'h00);
        direct    = 32'(aa[7:0] - dec_adj);
        direct_c  = dec_hi;
        bad       = bad || (size != sz_byte);
      end
      unsigned_product_op, signed_product_op:
      begin
        use_arith = 1'b0;
        upd_v     = 1'b0;
        upd_c     = 1'b0;
        upd_nz    = mul_sgn;
        wsize     = (size == sz_byte) ? sz_word : sz_long;
        fsize     = wsize;
        bad       = bad || (size == sz_long);
        if (size == sz_byte)
        begin
          mul_a = {{24{mul_sgn & dst_val[7]}}, dst_val[7:0]};
          mul_b = {{24{mul_sgn & src_gpr[7]}}, src_gpr[7:0]};
        end
        else
        begin
          mul_a = {{16{mul_sgn & dst_val[15]}}, dst_val[15:0]};
          mul_b = {{16{mul_sgn & src_gpr[15]}}, src_gpr[15:0]};
        end
        prod   = mul_a * mul_b;
        direct = prod;
      end
      unsigned_quotient_op, signed_quotient_op:
      begin
        use_arith = 1'b0;
        wr        = 1'b0;
        upd_nz    = 1'b0;
        upd_v     = 1'b0;
        upd_c     = 1'b0;
        bad       = bad || (size == sz_long);
        div_go    = 1'b1;
      end
      op_cmp:
      begin
        do_sub = 1'b1;
        upd_h  = 1'b1;
        wr     = 1'b0;
      end
      op_neg:
      begin
        aa     = 32'h0;
        ab     = dst_val & fm;
        do_sub = 1'b1;
        upd_h  = 1'b1;
      end
      zero_widen_op:
      begin
        use_arith = 1'b0;
        upd_c     = 1'b0;
        bad       = bad || (size == sz_byte);
        direct    = (size == sz_word) ? {24'h0, dst_val[7:0]}
                                      : {16'h0, dst_val[15:0]};
      end
      sign_widen_op:
      begin
        use_arith = 1'b0;
        upd_c     = 1'b0;
        bad       = bad || (size == sz_byte);
        direct    = (size == sz_word) ? {{24{dst_val[7]}}, dst_val[7:0]}
                                      : {{16{dst_val[15]}}, dst_val[15:0]};
      end
      op_and:
      begin
        use_arith = 1'b0;
        upd_c     = 1'b0;
        direct    = aa & ab;
      end
      op_or:
      begin
        use_arith = 1'b0;
        upd_c     = 1'b0;
        direct    = aa | ab;
      end
      op_xor:
      begin
        use_arith = 1'b0;
        upd_c     = 1'b0;
        direct    = aa ^ ab;
      end
      op_not:
      begin
        use_arith = 1'b0;
        upd_c     = 1'b0;
        direct    = ~aa & fm;
      end
      default:
      begin
        use_arith = 1'b0;
        bad       = 1'b1;
      end
    endcase
  end

  // ====
  // adder, flags and writeback merge
  always_comb
  begin
    if (do_sub)
      sum = {1'b0, aa} - {1'b0, ab} - 33'(cc);
    else
      sum = {1'b0, aa} + {1'b0, ab} + 33'(cc);
    rslt = use_arith ? (sum[31:0] & fm) : direct;
    hx   = aa ^ ab ^ sum[31:0];
    if (do_sub)
      ovf = (aa[msb_of(size)] != ab[msb_of(size)])
            && (sum[msb_of(size)] != aa[msb_of(size)]);
    else
      ovf = (aa[msb_of(size)] == ab[msb_of(size)])
            && (sum[msb_of(size)] != aa[msb_of(size)]);
    nf = flags_in;
    if (upd_nz)
    begin
      nf[FLAG_N] = rslt[msb_of(fsize)];
      nf[FLAG_Z] = ((rslt & width_mask(fsize)) == 32'h0)
                   && (!sticky_z || flags_in[FLAG_Z]);
    end
    if (upd_v)
      nf[FLAG_V] = use_arith && ovf;
    if (upd_c)
      nf[FLAG_C] = use_arith ? sum[msb_of(size) + 1] : direct_c;
    if (upd_h)
      nf[FLAG_H] = hx[half_of(size)];
    wm     = width_mask(wsize);
    merged = (dst_val & ~wm) | (rslt & wm);
  end

  // ====
  // divide operand preparation
  always_comb
  begin
    div_sgn = (op == signed_quotient_op);
    if (size == sz_byte)
    begin
      dd_s = {{16{div_sgn & dst_val[15]}}, dst_val[15:0]};
      dv_s = {{8{div_sgn & src_gpr[7]}}, src_gpr[7:0]};
    end
    else
    begin
      dd_s = dst_val;
      dv_s = src_gpr[15:0];
    end
    neg_a  = div_sgn && dd_s[31];
    neg_b  = div_sgn && dv_s[15];
    dd_abs = neg_a ? (32'h0 - dd_s) : dd_s;
    dv_abs = neg_b ? (16'h0 - dv_s) : dv_s;
  end

  alu_divider
  #(
    .NUM_W (DATA_W),
    .DEN_W (DEN_W)
  )
  u_divider
  (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .start    (acc && div_go && !bad),
    .dividend (dd_abs),
    .divisor  (dv_abs),
    .done_ff  (div_done),
    .quot_ff  (div_quot),
    .rem_ff   (div_rem)
  );

  // ====
  // divide result assembly
  always_comb
  begin
    q_fix     = ctx_nq_ff ? (32'h0 - div_quot) : div_quot;
    r_fix     = ctx_nr_ff ? (16'h0 - div_rem) : div_rem;
    div_flags = ctx_flags_ff;
    if (ctx_byte_ff)
    begin
      div_merged        = {ctx_dst_ff[31:16], r_fix[7:0], q_fix[7:0]};
      div_flags[FLAG_N] = q_fix[7];
    end
    else
    begin
      div_merged        = {r_fix, q_fix[15:0]};
      div_flags[FLAG_N] = q_fix[15];
    end
    div_flags[FLAG_Z] = ctx_zero_ff;
  end

  // ====
  // divide context
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ctx_dst_ff   <= 32'h0;
      ctx_byte_ff  <= 1'b0;
      ctx_nq_ff    <= 1'b0;
      ctx_nr_ff    <= 1'b0;
      ctx_zero_ff  <= 1'b0;
      ctx_flags_ff <= '0;
    end
    else if (acc && div_go && !bad)
    begin
      ctx_dst_ff   <= dst_val;
      ctx_byte_ff  <= (size == sz_byte);
      ctx_nq_ff    <= neg_a ^ neg_b;
      ctx_nr_ff    <= neg_a;
      ctx_zero_ff  <= (dv_s == 16'h0);
      ctx_flags_ff <= flags_in;
    end
  end

  // ====
  // busy tracking
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      busy_ff <= 1'b0;
    else if (acc && div_go && !bad)
      busy_ff <= 1'b1;
    else if (div_done)
      busy_ff <= 1'b0;
  end

  // ====
  // answer strobes
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      done_ff     <= 1'b0;
      bad_op_ff   <= 1'b0;
      wr_en_ff    <= 1'b0;
      flags_we_ff <= 1'b0;
    end
    else
    begin
      done_ff     <= (acc && (bad || !div_go)) || div_done;
      bad_op_ff   <= acc && bad;
      wr_en_ff    <= div_done || (acc && !bad && wr);
      flags_we_ff <= div_done || (acc && !bad && (upd_nz || upd_v || upd_c || upd_h));
    end
  end

  // ====
  // answer data
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      res_ff   <= 32'h0;
      flags_ff <= '0;
    end
    else if (div_done)
    begin
      res_ff   <= div_merged;
      flags_ff <= div_flags;
    end
    else if (acc)
    begin
      res_ff   <= merged;
      flags_ff <= nf;
    end
  end

endmodule : cpu_arith_logic_unit

// *** test/alu_checker_sva.sv ***
// alu_checker_sva: concurrent checks on the arithmetic and logic unit ports
`timescale 1ns/10ps
module alu_checker
(
  // clock and reset
  input logic              ref_clk,
  input logic              nrst,
  // request
  input logic              req_valid,
  input alu_pkg::op_type   op,
  input alu_pkg::size_type size,
  input logic              use_imm,
  input logic [31:0]       dst_val,
  input logic [31:0]       src_gpr,
  // answer
  input logic              busy_ff,
  input logic              done_ff,
  input logic              bad_op_ff,
  input logic              wr_en_ff,
  input logic [31:0]       res_ff,
  input logic              flags_we_ff
);
  import alu_pkg::*;
  // ====
  // helpers
  logic acc;
  logic div_acc;
  assign acc = req_valid && !busy_ff;
  assign div_acc = acc && (op inside {unsigned_quotient_op, signed_quotient_op})
                   && (size inside {sz_byte, sz_word});
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // ====
  // properties
  sequence s_div_run;
    busy_ff[*8] ##26 (done_ff && !busy_ff);
  endsequence
  property p_div_time;
    div_acc |=> s_div_run;
  endproperty
  property p_quick;
    acc && !div_acc |=> done_ff && !busy_ff;
  endproperty
  property p_bad_quiet;
    bad_op_ff |-> done_ff && !wr_en_ff && !flags_we_ff;
  endproperty
  property p_sub_imm;
    acc && op == op_sub && size == sz_byte && use_imm |=> bad_op_ff;
  endproperty
  property p_add;
    acc && op == op_add && size == sz_byte && !use_imm |=>
      res_ff == {$past(dst_val[31:8]), 8'($past(dst_val[7:0]) + $past(src_gpr[7:0]))};
  endproperty
  property p_cmp;
    acc && op == op_cmp && size != sz_bad |=> done_ff && !wr_en_ff && flags_we_ff;
  endproperty
  property p_neg;
    acc && op == op_neg && size == sz_byte |=> res_ff[7:0] == 8'(8'h00 - $past(dst_val[7:0]));
  endproperty
  property p_not;
    acc && op == op_not && size == sz_word |=> res_ff[15:0] == ~$past(dst_val[15:0]);
  endproperty
  property p_step;
    acc && op inside {addr_step_plus, addr_step_minus} |=> done_ff && !flags_we_ff;
  endproperty
  property p_zw;
    acc && op == zero_widen_op && size == sz_long |=> res_ff == {16'h0000, $past(dst_val[15:0])};
  endproperty
  a_div_time: assert property (p_div_time) else $error("divide timing wrong");
  a_quick: assert property (p_quick) else $error("no answer after one cycle");
  a_bad_quiet: assert property (p_bad_quiet) else $error("refused op wrote");
  a_sub_imm: assert property (p_sub_imm) else $error("byte imm subtract taken");
  a_add: assert property (p_add) else $error("byte add result wrong");
  a_cmp: assert property (p_cmp) else $error("compare wrote register");
  a_neg: assert property (p_neg) else $error("negate result wrong");
  a_not: assert property (p_not) else $error("not result wrong");
  a_step: assert property (p_step) else $error("address step wrote flags");
  a_zw: assert property (p_zw) else $error("zero widen wrong");
endmodule : alu_checker

bind cpu_arith_logic_unit alu_checker i_alu_checker (.*);

// *** test/alu_regfile_model.sv ***
// alu_regfile_model: destination register and condition flags register
`timescale 1ns/10ps
module alu_regfile_model
(
  // clock and reset
  input  logic        ref_clk,
  input  logic        nrst,
  // preload
  input  logic        load,
  input  logic [31:0] load_val,
  input  logic [4:0]  load_flags,
  // write back
  input  logic        wr_en_ff,
  input  logic [31:0] res_ff,
  input  logic        flags_we_ff,
  input  logic [4:0]  flags_ff,
  // register contents
  output logic [31:0] reg_ff,
  output logic [4:0]  ccr_ff
);
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      reg_ff <= 32'h00000000;
      ccr_ff <= 5'h00;
    end
    else if (load)
    begin
      reg_ff <= load_val;
      ccr_ff <= load_flags;
    end
    else
    begin
      if (wr_en_ff)
        reg_ff <= res_ff;
      if (flags_we_ff)
        ccr_ff <= flags_ff;
    end
  end
endmodule : alu_regfile_model

// *** test/cpu_arith_logic_unit_test.sv ***
// cpu_arith_logic_unit_test: self-checking bench of the arithmetic and logic unit
`timescale 1ns/10ps
module cpu_arith_logic_unit_test;
  import alu_pkg::*;
  logic ref_clk, nrst, req_valid, use_imm, load, busy_ff, done_ff, bad_op_ff;
  logic wr_en_ff, flags_we_ff, bad;
  op_type op;
  size_type size;
  logic [2:0] step_val;
  logic [31:0] src_gpr, imm_val, load_val, res_ff, reg_ff;
  logic [4:0] load_flags, flags_ff, ccr_ff;
  int num_errors, checks_done, lat;
  cpu_arith_logic_unit i_cpu_arith_logic_unit (.*, .dst_val(reg_ff), .flags_in(ccr_ff));
  alu_regfile_model i_alu_regfile_model (.*);
  // ====
  // shared tasks
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask : check
  task automatic go(input op_type o, input size_type z, input logic i, input logic [2:0] st,
                    input logic [31:0] d, input logic [31:0] s, input logic [4:0] f,
                    input int hold);
    int n;
    @(negedge ref_clk);
    load = 1;
    load_val = d;
    load_flags = f;
    @(negedge ref_clk);
    load = 0;
    req_valid = 1;
    {op, size, use_imm, step_val, src_gpr, imm_val} = {o, z, i, st, s, s};
    repeat (hold + 1) @(negedge ref_clk);
    req_valid = 0;
    n = hold + 1;
    while (done_ff !== 1'b1 && n < 60)
    begin
      @(negedge ref_clk);
      n++;
    end
    lat = n;
    bad = bad_op_ff;
    @(negedge ref_clk);
  endtask : go
  task automatic ok(input string w, input logic [31:0] r, input logic [4:0] m,
                    input logic [4:0] f, input int l);
    check({w, " latency"}, l, lat);
    check({w, " refused"}, 0, bad);
    check(w, r, reg_ff);
    check({w, " flags"}, f, ccr_ff & m);
  endtask : ok
  task automatic nope(input string w);
    check({w, " latency"}, 1, lat);
    check({w, " refused"}, 1, bad);
  endtask : nope
  // ====
  // scenarios
  task automatic t_add_sub;
    go(op_add, sz_byte, 0, 0, 32'h123456f0, 32'h20, 5'h00, 0);
    ok("add", 32'h12345610, 5'h1f, 5'h01, 1);
    go(op_sub, sz_word, 1, 0, 32'h5, 32'h6, 5'h00, 0);
    ok("sub", 32'hffff, 5'h1f, 5'h19, 1);
    go(op_sub, sz_byte, 1, 0, 32'h5, 32'h1, 5'h00, 0);
    nope("sub imm");
    go(op_add, sz_bad, 0, 0, 32'h5, 32'h1, 5'h00, 0);
    nope("bad size");
  endtask : t_add_sub
  task automatic t_carry;
    go(carry_sum_op, sz_byte, 0, 0, 32'h60, 32'h1f, 5'h01, 0);
    ok("carry sum", 32'h80, 5'h0f, 5'h0a, 1);
    go(borrow_diff_op, sz_byte, 1, 0, 32'h0, 32'h0, 5'h05, 0);
    ok("borrow diff", 32'hff, 5'h0f, 5'h09, 1);
    go(borrow_diff_op, sz_word, 0, 0, 32'h0, 32'h0, 5'h00, 0);
    nope("borrow word");
  endtask : t_carry
  task automatic t_step;
    go(op_inc, sz_word, 0, 2, 32'h7fff, 32'h0, 5'h01, 0);
    ok("inc", 32'h8001, 5'h0f, 5'h0b, 1);
    go(op_dec, sz_byte, 0, 1, 32'hab00, 32'h0, 5'h00, 0);
    ok("dec", 32'habff, 5'h0f, 5'h08, 1);
    go(op_inc, sz_byte, 0, 2, 32'h1, 32'h0, 5'h00, 0);
    nope("inc byte two");
    go(addr_step_minus, sz_long, 0, 4, 32'h2, 32'h0, 5'h15, 0);
    ok("step minus", 32'hfffffffe, 5'h1f, 5'h15, 1);
    go(addr_step_plus, sz_long, 0, 1, 32'hffffffff, 32'h0, 5'h0a, 0);
    ok("step plus", 32'h0, 5'h1f, 5'h0a, 1);
    go(addr_step_plus, sz_word, 0, 1, 32'h1, 32'h0, 5'h00, 0);
    nope("step word");
    go(addr_step_plus, sz_long, 0, 3, 32'h1, 32'h0, 5'h00, 0);
    nope("step three");
  endtask : t_step
  task automatic t_decimal;
    go(decimal_fix_after_plus, sz_byte, 0, 0, 32'h9a, 32'h0, 5'h00, 0);
    ok("fix plus", 32'h0, 5'h0f, 5'h05, 1);
    go(decimal_fix_after_minus, sz_byte, 0, 0, 32'h0f, 32'h0, 5'h10, 0);
    ok("fix minus", 32'h09, 5'h0f, 5'h00, 1);
    go(decimal_fix_after_plus, sz_word, 0, 0, 32'h9a, 32'h0, 5'h00, 0);
    nope("fix word");
  endtask : t_decimal
  task automatic t_mul;
    go(unsigned_product_op, sz_byte, 0, 0, 32'h123400ff, 32'hff, 5'h0a, 0);
    ok("umul", 32'h1234fe01, 5'h1f, 5'h0a, 1);
    go(signed_product_op, sz_word, 0, 0, 32'hffff, 32'h2, 5'h00, 0);
    ok("smul", 32'hfffffffe, 5'h0c, 5'h08, 1);
    go(unsigned_product_op, sz_long, 0, 0, 32'h2, 32'h2, 5'h00, 0);
    nope("umul long");
  endtask : t_mul
  task automatic t_div;
    go(unsigned_quotient_op, sz_byte, 0, 0, 32'haaaa0064, 32'h7, 5'h00, 1);
    ok("udiv", 32'haaaa020e, 5'h0c, 5'h00, 34);
    go(signed_quotient_op, sz_word, 0, 0, 32'hfffffff9, 32'h2, 5'h00, 0);
    ok("sdiv", 32'hfffffffd, 5'h0c, 5'h08, 34);
    go(unsigned_quotient_op, sz_long, 0, 0, 32'h9, 32'h2, 5'h00, 0);
    nope("udiv long");
  endtask : t_div
  task automatic t_cmp_neg;
    go(op_cmp, sz_long, 1, 0, 32'h5, 32'h5, 5'h00, 0);
    ok("cmp", 32'h5, 5'h1f, 5'h04, 1);
    go(op_neg, sz_byte, 0, 0, 32'h80, 32'h0, 5'h00, 0);
    ok("neg byte", 32'h80, 5'h0f, 5'h0b, 1);
    go(op_neg, sz_long, 0, 0, 32'h1, 32'h0, 5'h00, 0);
    ok("neg long", 32'hffffffff, 5'h0f, 5'h09, 1);
  endtask : t_cmp_neg
  task automatic t_widen;
    go(zero_widen_op, sz_long, 0, 0, 32'habcd8123, 32'h0, 5'h01, 0);
    ok("zero widen", 32'h8123, 5'h0f, 5'h01, 1);
    go(sign_widen_op, sz_word, 0, 0, 32'h12340080, 32'h0, 5'h00, 0);
    ok("sign widen", 32'h1234ff80, 5'h0f, 5'h08, 1);
    go(sign_widen_op, sz_byte, 0, 0, 32'h80, 32'h0, 5'h00, 0);
    nope("widen byte");
  endtask : t_widen
  task automatic t_logic;
    go(op_and, sz_long, 0, 0, 32'hf0f0f0f0, 32'hff00ff00, 5'h00, 0);
    ok("and", 32'hf000f000, 5'h0f, 5'h08, 1);
    go(op_or, sz_word, 1, 0, 32'h12340f0f, 32'hf000, 5'h00, 0);
    ok("or", 32'h1234ff0f, 5'h0f, 5'h08, 1);
    go(op_xor, sz_byte, 0, 0, 32'h555555aa, 32'haa, 5'h00, 0);
    ok("xor", 32'h55555500, 5'h0f, 5'h04, 1);
    go(op_not, sz_word, 0, 0, 32'hffff, 32'h0, 5'h03, 0);
    ok("not", 32'h0, 5'h0f, 5'h05, 1);
  endtask : t_logic
  // ====
  // verdict, clock, watchdog and main sequence
  task automatic final_report;
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial
  begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end
  initial
  begin
    {nrst, req_valid, use_imm, load, step_val, src_gpr, imm_val, load_val, load_flags} = 0;
    op = op_add;
    size = sz_byte;
    repeat (6) @(negedge ref_clk);
    nrst = 1;
    t_add_sub();
    t_carry();
    t_step();
    t_decimal();
    t_mul();
    t_div();
    t_cmp_neg();
    t_widen();
    t_logic();
    final_report();
  end
endmodule : cpu_arith_logic_unit_test
